// [verilog/lcd_rotation_map.svh]
// Register offsets, field positions, colour depth codes, reset values and the cursor clamp limit of the panel rotation block.
// Assumes an 8-bit register port with byte addresses; one clock, synchronous reset.
`ifndef LCD_ROTATION_MAP_SVH
`define LCD_ROTATION_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_PANEL_MODE        9'h040
`define OFS_START_B0          9'h042
`define OFS_START_B1          9'h043
`define OFS_START_B2          9'h044
`define OFS_LINE_OFS_LO       9'h046
`define OFS_LINE_OFS_HI       9'h047
`define OFS_GLOBAL_MODE       9'h1FC
`define OFS_CUR_X_LO          9'h060
`define OFS_CUR_X_HI          9'h061
`define OFS_CUR_Y_LO          9'h062
`define OFS_CUR_Y_HI          9'h063
`define OFS_ROT_STATUS        9'h064

// ----------------------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------------------
`define BIT_PANEL_BLANK       7
`define BIT_ROT_HIGH          4
`define BIT_ROT_LOW           6
`define MASK_PANEL_MODE       8'h97
`define MASK_GLOBAL_MODE      8'h47
`define MASK_LINE_OFS_HI      8'h07
`define MASK_START_B2         8'h0F
`define BIT_CUR_SIGN          7
`define MASK_CUR_MAG_HI       8'h7F
`define CUR_MIN_NEG_MAG       11'h03F

// ----------------------------------------------------------------------------
// Colour depth codes and reset values
// ----------------------------------------------------------------------------
`define BPP_8                 3'h3
`define BPP_15                3'h4
`define BPP_16                3'h5
`define RST_BYTE              8'h00

`endif

// [verilog/lcd_rotation_pkg.sv]
// Types shared by the panel rotation block.
// Assumes the register map header is included by the design files.
package lcd_rotation_pkg;
   typedef enum logic [1:0] {
      ROT_0,
      ROT_90,
      ROT_180,
      ROT_270
   } rotation_t;

   typedef enum logic [1:0] {
      PATH_PANEL,
      PATH_CRT,
      PATH_TV
   } display_path_t;
endpackage

// [verilog/cursor_coord.sv]
// One sign-magnitude cursor coordinate with a pending and an applied copy.
// Assumes byte writes arrive from the register port of the rotation block.
`include "lcd_rotation_map.svh"

module cursor_coord (
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        reset_i,
   // Byte writes and commit
   input  wire logic        wr_lo_i,
   input  wire logic        wr_hi_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        commit_i,
   // Values
   output logic      [7:0]  pend_lo_o,
   output logic      [7:0]  pend_hi_o,
   output logic      [10:0] mag_o,
   output logic             neg_o
);
   logic [7:0]  lo_ff;
   logic [7:0]  hi_ff;
   logic [10:0] mag_ff;
   logic        neg_ff;
   logic [7:0]  nxt_lo;
   logic [7:0]  nxt_hi;
   logic [10:0] nxt_mag;
   logic        nxt_neg;
   logic [10:0] cand_mag;

   always_comb begin
      nxt_lo  = wr_lo_i ? wdata_i : lo_ff;
      nxt_hi  = wr_hi_i ? wdata_i : hi_ff;
      cand_mag = {nxt_hi[2:0], nxt_lo};
      nxt_mag = mag_ff;
      nxt_neg = neg_ff;
      if (commit_i) begin
         // Negative positions beyond the cursor size would leave nothing visible, so they clamp.
         nxt_neg = nxt_hi[`BIT_CUR_SIGN];
         if (nxt_hi[`BIT_CUR_SIGN] && cand_mag > `CUR_MIN_NEG_MAG) begin
            nxt_mag = `CUR_MIN_NEG_MAG;
         end else begin
            nxt_mag = cand_mag;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         lo_ff  <= `RST_BYTE;
         hi_ff  <= `RST_BYTE;
         mag_ff <= 11'h000;
         neg_ff <= 1'b0;
      end else begin
         lo_ff  <= nxt_lo;
         hi_ff  <= nxt_hi;
         mag_ff <= nxt_mag;
         neg_ff <= nxt_neg;
      end
   end

   assign pend_lo_o = lo_ff;
   assign pend_hi_o = hi_ff;
   assign mag_o     = mag_ff;
   assign neg_o     = neg_ff;

   clamp_neg_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      neg_ff |-> mag_ff <= `CUR_MIN_NEG_MAG) else $error("negative cursor beyond -63");
endmodule

// [verilog/lcd_rotation.sv]
// Panel rotation setup: mode, start address, line offset and cursor position registers.
// Assumes a simple byte register port with one-cycle strobes and the refresh path as consumer.
//
// Local design decision: the plain strobed port.
`include "lcd_rotation_map.svh"

module lcd_rotation (
   // Clock and reset
   input  wire logic                           sys_clk_i,
   input  wire logic                           reset_i,
   // Register port
   input  wire logic [8:0]                     addr_i,
   input  wire logic [7:0]                     wdata_i,
   input  wire logic                           wr_i,
   input  wire logic                           rd_i,
   output logic      [7:0]                     rdata_o,
   // Refresh path selection
   input  wire lcd_rotation_pkg::display_path_t path_i,
   // Panel refresh settings
   output lcd_rotation_pkg::rotation_t         panel_rot_o,
   output logic                                panel_rot_active_o,
   output logic                                panel_blank_o,
   output logic      [2:0]                     panel_bpp_o,
   output logic      [2:0]                     display_mode_o,
   output logic      [19:0]                    start_addr_o,
   output logic      [10:0]                    line_offset_o,
   // Cursor position
   output logic      [10:0]                    cur_x_mag_o,
   output logic                                cur_x_neg_o,
   output logic      [10:0]                    cur_y_mag_o,
   output logic                                cur_y_neg_o
);
   import lcd_rotation_pkg::*;

   // -------------------------------------------------------------------------
   // Register storage
   // -------------------------------------------------------------------------
   logic [7:0]  panel_mode_ff;
   logic [7:0]  global_mode_ff;
   logic [19:0] start_ff;
   logic [10:0] line_ofs_ff;
   logic [7:0]  nxt_panel_mode;
   logic [7:0]  nxt_global_mode;
   logic [19:0] nxt_start;
   logic [10:0] nxt_line_ofs;

   always_comb begin
      nxt_panel_mode  = panel_mode_ff;
      nxt_global_mode = global_mode_ff;
      nxt_start       = start_ff;
      nxt_line_ofs    = line_ofs_ff;
      if (wr_i) begin
         case (addr_i)
            `OFS_PANEL_MODE: begin
               nxt_panel_mode = wdata_i & `MASK_PANEL_MODE;
            end
            `OFS_GLOBAL_MODE: begin
               nxt_global_mode = wdata_i & `MASK_GLOBAL_MODE;
            end
            `OFS_START_B0: begin
               nxt_start[7:0] = wdata_i;
            end
            `OFS_START_B1: begin
               nxt_start[15:8] = wdata_i;
            end
            `OFS_START_B2: begin
               nxt_start[19:16] = wdata_i[3:0];
            end
            `OFS_LINE_OFS_LO: begin
               nxt_line_ofs[7:0] = wdata_i;
            end
            `OFS_LINE_OFS_HI: begin
               nxt_line_ofs[10:8] = wdata_i[2:0];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         panel_mode_ff  <= `RST_BYTE;
         global_mode_ff <= `RST_BYTE;
         start_ff       <= 20'h00000;
         line_ofs_ff    <= 11'h000;
      end else begin
         panel_mode_ff  <= nxt_panel_mode;
         global_mode_ff <= nxt_global_mode;
         start_ff       <= nxt_start;
         line_ofs_ff    <= nxt_line_ofs;
      end
   end

   // -------------------------------------------------------------------------
   // Cursor position
   // -------------------------------------------------------------------------
   logic        wr_cur_xl;
   logic        wr_cur_xh;
   logic        wr_cur_yl;
   logic        wr_cur_yh;
   logic [7:0]  cxl;
   logic [7:0]  cxh;
   logic [7:0]  cyl;
   logic [7:0]  cyh;
   logic [10:0] cx_mag;
   logic [10:0] cy_mag;
   logic        cx_neg;
   logic        cy_neg;

   assign wr_cur_xl = wr_i && addr_i == `OFS_CUR_X_LO;
   assign wr_cur_xh = wr_i && addr_i == `OFS_CUR_X_HI;
   assign wr_cur_yl = wr_i && addr_i == `OFS_CUR_Y_LO;
   // The whole position moves at once so the cursor never shows a half-updated spot.
   assign wr_cur_yh = wr_i && addr_i == `OFS_CUR_Y_HI;

   cursor_coord u_cur_x (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .wr_lo_i   (wr_cur_xl),
      .wr_hi_i   (wr_cur_xh),
      .wdata_i   (wdata_i),
      .commit_i  (wr_cur_yh),
      .pend_lo_o (cxl),
      .pend_hi_o (cxh),
      .mag_o     (cx_mag),
      .neg_o     (cx_neg)
   );

   cursor_coord u_cur_y (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .wr_lo_i   (wr_cur_yl),
      .wr_hi_i   (wr_cur_yh),
      .wdata_i   (wdata_i),
      .commit_i  (wr_cur_yh),
      .pend_lo_o (cyl),
      .pend_hi_o (cyh),
      .mag_o     (cy_mag),
      .neg_o     (cy_neg)
   );

   // -------------------------------------------------------------------------
   // Rotation decode
   // -------------------------------------------------------------------------
   rotation_t req_rot;
   logic      bpp_ok;
   logic      rot_allowed;
   rotation_t eff_rot;

   always_comb begin
      // High bit from the panel mode register, low bit from the global mode register.
      case ({panel_mode_ff[`BIT_ROT_HIGH], global_mode_ff[`BIT_ROT_LOW]})
         2'b00: req_rot = ROT_0;
         2'b01: req_rot = ROT_90;
         2'b10: req_rot = ROT_180;
         2'b11: req_rot = ROT_270;
         default: req_rot = ROT_0;
      endcase
      bpp_ok = panel_mode_ff[2:0] == `BPP_8 || panel_mode_ff[2:0] == `BPP_15
               || panel_mode_ff[2:0] == `BPP_16;
      // Other display paths always refresh unrotated, whatever the bits hold.
      rot_allowed = bpp_ok && path_i == PATH_PANEL;
      // Clockwise turn relative to the native panel orientation; the refresh path walks memory accordingly.
      eff_rot = rot_allowed ? req_rot : ROT_0;
   end

   // -------------------------------------------------------------------------
   // Read path and registered outputs
   // -------------------------------------------------------------------------
   logic [7:0] nxt_rdata;
   logic [7:0] rdata_ff;
   rotation_t  rot_ff;
   logic       rot_active_ff;
   logic       blank_ff;
   logic [2:0] bpp_ff;
   logic [2:0] dmode_ff;
   logic [19:0] start_out_ff;
   logic [10:0] line_out_ff;
   logic [10:0] cxm_ff;
   logic [10:0] cym_ff;
   logic        cxn_ff;
   logic        cyn_ff;

   always_comb begin
      nxt_rdata = 8'h00;
      if (rd_i) begin
         case (addr_i)
            `OFS_PANEL_MODE:  nxt_rdata = panel_mode_ff;
            `OFS_GLOBAL_MODE: nxt_rdata = global_mode_ff;
            `OFS_START_B0:    nxt_rdata = start_ff[7:0];
            `OFS_START_B1:    nxt_rdata = start_ff[15:8];
            `OFS_START_B2:    nxt_rdata = {4'h0, start_ff[19:16]};
            `OFS_LINE_OFS_LO: nxt_rdata = line_ofs_ff[7:0];
            `OFS_LINE_OFS_HI: nxt_rdata = {5'h00, line_ofs_ff[10:8]};
            `OFS_CUR_X_LO:    nxt_rdata = cxl;
            `OFS_CUR_X_HI:    nxt_rdata = cxh;
            `OFS_CUR_Y_LO:    nxt_rdata = cyl;
            `OFS_CUR_Y_HI:    nxt_rdata = cyh;
            `OFS_ROT_STATUS:  nxt_rdata = {5'h00, rot_allowed, eff_rot};
            default:          nxt_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         rdata_ff      <= 8'h00;
         rot_ff        <= ROT_0;
         rot_active_ff <= 1'b0;
         blank_ff      <= 1'b0;
         bpp_ff        <= 3'h0;
         dmode_ff      <= 3'h0;
         start_out_ff  <= 20'h00000;
         line_out_ff   <= 11'h000;
         cxm_ff        <= 11'h000;
         cym_ff        <= 11'h000;
         cxn_ff        <= 1'b0;
         cyn_ff        <= 1'b0;
      end else begin
         rdata_ff      <= nxt_rdata;
         rot_ff        <= eff_rot;
         rot_active_ff <= rot_allowed && eff_rot != ROT_0;
         blank_ff      <= panel_mode_ff[`BIT_PANEL_BLANK];
         bpp_ff        <= panel_mode_ff[2:0];
         dmode_ff      <= global_mode_ff[2:0];
         start_out_ff  <= start_ff;
         line_out_ff   <= line_ofs_ff;
         cxm_ff        <= cx_mag;
         cym_ff        <= cy_mag;
         cxn_ff        <= cx_neg;
         cyn_ff        <= cy_neg;
      end
   end

   assign rdata_o            = rdata_ff;
   assign panel_rot_o        = rot_ff;
   assign panel_rot_active_o = rot_active_ff;
   assign panel_blank_o      = blank_ff;
   assign panel_bpp_o        = bpp_ff;
   assign display_mode_o     = dmode_ff;
   assign start_addr_o       = start_out_ff;
   assign line_offset_o      = line_out_ff;
   assign cur_x_mag_o        = cxm_ff;
   assign cur_x_neg_o        = cxn_ff;
   assign cur_y_mag_o        = cym_ff;
   assign cur_y_neg_o        = cyn_ff;

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   rot_decode_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      rot_allowed |=> panel_rot_o == $past(req_rot)) else $error("rotation decode wrong");
   bpp_gate_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      !bpp_ok |=> panel_rot_o == ROT_0) else $error("rotation at unsupported depth");
   other_path_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      path_i != PATH_PANEL |=> !panel_rot_active_o) else $error("rotation on CRT or TV");
   line_hi_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      wr_i && addr_i == `OFS_LINE_OFS_HI |=> ##1 line_offset_o[10:8] == $past(wdata_i[2:0], 2))
      else $error("line offset high bits lost");
   start_top_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      rd_i && addr_i == `OFS_START_B2 |=> rdata_o[7:4] == 4'h0) else $error("start top nibble not zero");
   cur_hold_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      !wr_cur_yh |=> ##1 $stable(cur_x_mag_o) && $stable(cur_y_neg_o)) else $error("cursor moved early");
   cur_sign_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      wr_cur_yh |=> ##1 cur_y_neg_o == $past(wdata_i[7], 2)) else $error("cursor sign not taken");
   rot_clockwise_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      rot_allowed && !panel_mode_ff[`BIT_ROT_HIGH] && global_mode_ff[`BIT_ROT_LOW]
      |=> panel_rot_o == ROT_90 && panel_rot_active_o) else $error("quarter turn not clockwise");
   // X holds its pending bytes while Y high is written, so a non-negative applied X must equal them.
   cur_commit_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      wr_cur_yh && !cxh[`BIT_CUR_SIGN] |=> ##1 cur_x_mag_o == $past({cxh[2:0], cxl}, 2))
      else $error("cursor x not applied");
endmodule

// [tb/lcd_host_model.sv]
// Host processor model: drives the byte register port and works out setup values.
// Assumes the block samples strobes on the rising edge and answers reads one cycle later.
`include "lcd_rotation_map.svh"

module lcd_host_model (
   // Clock
   input  wire logic       sys_clk_i,
   // Register port
   output logic      [8:0] addr_o,
   output logic      [7:0] wdata_o,
   output logic            wr_o,
   output logic            rd_o,
   input  wire logic [7:0] rdata_i
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      addr_o  = 9'h000;
      wdata_o = 8'h00;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
   end

   // ---------------------------------------------------------------------
   // Bus cycles
   // ---------------------------------------------------------------------
   task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      addr_o  <= a;
      wdata_o <= d;
      wr_o    <= 1'b1;
      @(posedge sys_clk_i);
      wr_o    <= 1'b0;
      wdata_o <= ~d;
   endtask

   task automatic rd_reg(input logic [8:0] a, output logic [7:0] d);
      @(posedge sys_clk_i);
      addr_o <= a;
      rd_o   <= 1'b1;
      @(posedge sys_clk_i);
      rd_o   <= 1'b0;
      #1;
      d = rdata_i;
   endtask

   // ---------------------------------------------------------------------
   // Setup values
   // ---------------------------------------------------------------------
   // Low byte first, then the high byte with the sign in its top bit.
   task automatic wr_coord(input logic [8:0] lo_addr, input int v);
      int mag;
      mag = (v < 0) ? -v : v;
      wr_reg(lo_addr, mag[7:0]);
      wr_reg(lo_addr + 9'h001, mag[15:8] | ((v < 0) ? 8'h80 : 8'h00));
   endtask

   task automatic set_geometry(input logic [1:0] rot, input bit deep, input int panel_width_px,
                               input int panel_height_lines, output int ofs, output int start);
      int stride;
      ofs = rot[0] ? (deep ? 1024 : 512) : (deep ? panel_width_px : panel_width_px / 2);
      stride = ofs * 2;
      case (rot)
         2'h0: start = 0;
         2'h1: start = deep ? (1024 - panel_width_px) / 2 : 1024 - panel_width_px;
         2'h2: begin
            if (deep) begin
               start = (stride * panel_height_lines - (stride - 2 * panel_width_px)) / 2 - 1;
            end else begin
               start = (stride * panel_height_lines - (stride - panel_width_px)) / 2 - 1;
            end
         end
         default: start = (stride * panel_height_lines) / 2 - 1;
      endcase
      wr_reg(`OFS_LINE_OFS_LO, ofs[7:0]);
      wr_reg(`OFS_LINE_OFS_HI, ofs[15:8]);
      wr_reg(`OFS_START_B0, start[7:0]);
      wr_reg(`OFS_START_B1, start[15:8]);
      wr_reg(`OFS_START_B2, start[23:16]);
   endtask

   // Cursor registers take unrotated panel coordinates.
   task automatic map_cursor(input logic [1:0] rot, input int x, input int y, input int dw, input int dh,
                             output int cx, output int cy);
      case (rot)
         2'h0: begin
            cx = x;
            cy = y;
         end
         2'h1: begin
            cy = x;
            cx = dw - y - 64;
         end
         2'h2: begin
            cx = dw - x - 64;
            cy = dh - y - 64;
         end
         default: begin
            cy = dw - x - 64;
            cx = y;
         end
      endcase
   endtask
endmodule

// [tb/lcd_rotation_tb.sv]
// Self-checking bench for the panel rotation setup block.
// Assumes the host model owns the register port; the bench drives the path select and reset.
`include "lcd_rotation_map.svh"

module lcd_rotation_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import lcd_rotation_pkg::*;

   logic          sys_clk, reset;
   logic [8:0]    addr;
   logic [7:0]    wdata, rdata, rd_val;
   logic          wr, rd;
   display_path_t path;
   rotation_t     panel_rot;
   logic          rot_active, blank, x_neg, y_neg;
   logic [2:0]    bpp, disp_mode;
   logic [19:0]   start_addr;
   logic [10:0]   line_ofs, x_mag, y_mag;
   logic [11:0]   exp_x;
   int            bad_count, num_checks, ofs, start, cx, cy;

   lcd_rotation u_lcd_rotation (.sys_clk_i(sys_clk), .reset_i(reset), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .path_i(path), .panel_rot_o(panel_rot),
      .panel_rot_active_o(rot_active), .panel_blank_o(blank), .panel_bpp_o(bpp),
      .display_mode_o(disp_mode), .start_addr_o(start_addr), .line_offset_o(line_ofs),
      .cur_x_mag_o(x_mag), .cur_x_neg_o(x_neg), .cur_y_mag_o(y_mag), .cur_y_neg_o(y_neg));

   lcd_host_model u_lcd_host_model (.sys_clk_i(sys_clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
      .rd_o(rd), .rdata_i(rdata));

   // ---------------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------------
   task automatic check(input logic [19:0] seen, input logic [19:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // Settings outputs lag a write by two edges; three leaves margin.
   task automatic settle();
      repeat (3) @(posedge sys_clk);
      #1;
   endtask

   function automatic logic [11:0] sm(input int v);
      int m;
      m = (v < 0) ? ((-v > 63) ? 63 : -v) : v;
      return {v < 0, m[10:0]};
   endfunction

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ---------------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------------
   task automatic test_reset();
      #1;
      check({panel_rot, rot_active, x_neg, y_neg}, 0, "reset flags");
      check(start_addr, 0, "reset start");
      u_lcd_host_model.rd_reg(`OFS_PANEL_MODE, rd_val);
      check(rd_val, 0, "reset mode");
      $display("test_reset done");
   endtask

   task automatic test_rotation();
      for (int r = 0; r < 4; r++) begin
         u_lcd_host_model.wr_reg(`OFS_PANEL_MODE, {3'h0, r[1], 1'b0, `BPP_16});
         u_lcd_host_model.wr_reg(`OFS_GLOBAL_MODE, {1'b0, r[0], 6'h00});
         settle();
         check(panel_rot, r[1:0], "rotation");
         check(rot_active, r != 0, "active");
      end
      $display("test_rotation done");
   endtask

   task automatic test_depth_path();
      u_lcd_host_model.wr_reg(`OFS_GLOBAL_MODE, 8'hFF);
      for (int b = 0; b < 8; b++) begin
         u_lcd_host_model.wr_reg(`OFS_PANEL_MODE, {5'h02, b[2:0]});
         settle();
         check(panel_rot, (b >= 3 && b <= 5) ? 2'h3 : 2'h0, "depth gate");
         check(bpp, b[2:0], "depth");
      end
      u_lcd_host_model.rd_reg(`OFS_GLOBAL_MODE, rd_val);
      check(rd_val, 8'h47, "global mask");
      check({disp_mode, blank}, 4'hE, "mode and blank");
      u_lcd_host_model.wr_reg(`OFS_PANEL_MODE, 8'hFF);
      u_lcd_host_model.rd_reg(`OFS_PANEL_MODE, rd_val);
      check(rd_val, 8'h97, "panel mask");
      check(blank, 1'b1, "blank");
      u_lcd_host_model.wr_reg(`OFS_PANEL_MODE, 8'h14);
      path <= PATH_CRT;
      settle();
      check(panel_rot, 2'h0, "crt path");
      u_lcd_host_model.rd_reg(`OFS_ROT_STATUS, rd_val);
      check(rd_val, 8'h00, "crt status");
      path <= PATH_TV;
      settle();
      check({panel_rot, rot_active}, 3'h0, "tv path");
      path <= PATH_PANEL;
      settle();
      check(panel_rot, 2'h3, "panel path");
      u_lcd_host_model.rd_reg(`OFS_ROT_STATUS, rd_val);
      check(rd_val, 8'h07, "panel status");
      $display("test_depth_path done");
   endtask

   task automatic test_geometry();
      for (int r = 0; r < 4; r++) begin
         u_lcd_host_model.set_geometry(r[1:0], r != 3, 640, 480, ofs, start);
         settle();
         check(line_ofs, ofs[10:0], "line offset");
         check(start_addr, start[19:0], "start address");
      end
      u_lcd_host_model.wr_reg(`OFS_START_B2, 8'hFF);
      u_lcd_host_model.wr_reg(`OFS_LINE_OFS_HI, 8'hFF);
      u_lcd_host_model.rd_reg(`OFS_START_B2, rd_val);
      check(rd_val, 8'h0F, "start top byte");
      u_lcd_host_model.rd_reg(`OFS_LINE_OFS_HI, rd_val);
      check(rd_val, 8'h07, "offset top byte");
      u_lcd_host_model.rd_reg(9'h1FF, rd_val);
      check(rd_val, 8'h00, "unmapped read");
      #2;
      check({start_addr[19:16], line_ofs[10:8]}, 7'h7F, "top bits");
      $display("test_geometry done");
   endtask

   task automatic put_cursor(input int x, input int y);
      u_lcd_host_model.wr_coord(`OFS_CUR_X_LO, x);
      settle();
      check({x_neg, x_mag}, exp_x, "x applied early");
      u_lcd_host_model.wr_coord(`OFS_CUR_Y_LO, y);
      settle();
      exp_x = sm(x);
      check({x_neg, x_mag}, exp_x, "cursor x");
      check({y_neg, y_mag}, sm(y), "cursor y");
   endtask

   task automatic test_cursor();
      for (int r = 0; r < 4; r++) begin
         u_lcd_host_model.map_cursor(r[1:0], 100, 450, 480, 640, cx, cy);
         put_cursor(cx, cy);
      end
      put_cursor(-63, 1500);
      put_cursor(1500, -200);
      u_lcd_host_model.rd_reg(`OFS_CUR_X_LO, rd_val);
      check(rd_val, 8'hDC, "x low byte");
      u_lcd_host_model.rd_reg(`OFS_CUR_Y_HI, rd_val);
      check(rd_val, 8'h80, "y high byte");
      $display("test_cursor done");
   endtask

   // Reset in mid-run must clear everything and let the first strobe follow at once.
   task automatic test_mid_reset();
      @(posedge sys_clk);
      reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      #1;
      check({panel_rot, rot_active, x_neg, y_neg}, 0, "mid reset flags");
      check(start_addr, 0, "mid reset start");
      check(line_ofs, 0, "mid reset offset");
      check(x_mag, 0, "mid reset x");
      check(y_mag, 0, "mid reset y");
      u_lcd_host_model.rd_reg(`OFS_CUR_X_LO, rd_val);
      check(rd_val, 8'h00, "mid reset read");
      $display("test_mid_reset done");
   endtask

   // ---------------------------------------------------------------------
   // Clock, reset, sequence and watchdog
   // ---------------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   initial begin
      reset = 1'b1;
      path  = PATH_PANEL;
      exp_x = 12'h000;
      repeat (20) @(posedge sys_clk);
      reset <= 1'b0;
      test_reset();
      test_rotation();
      test_depth_path();
      test_geometry();
      test_cursor();
      test_mid_reset();
      stop_test();
   end

   // The whole run needs a few hundred clock cycles; this allows ample slack.
   initial begin
      #800000;
      bad_count++;
      stop_test();
   end
endmodule
